/* File: inc/fsb_pkg.sv */
// package of constants, types and register map for the fault status and blink code block
package fsb_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam int FSB_AW = 8;
    localparam logic [FSB_AW-1:0] FSB_OFS_DIN = 8'h00;
    localparam logic [FSB_AW-1:0] FSB_OFS_DOUT = 8'h04;
    localparam logic [FSB_AW-1:0] FSB_OFS_ERR = 8'h08;
    localparam logic [FSB_AW-1:0] FSB_OFS_WIN = 8'h0C;
    localparam logic [FSB_AW-1:0] FSB_OFS_THR = 8'h10;
    localparam logic [FSB_AW-1:0] FSB_OFS_CVAL = 8'h14;
    localparam logic [FSB_AW-1:0] FSB_OFS_STAT = 8'h18;
    localparam logic [FSB_AW-1:0] FSB_OFS_CFG = 8'h1C;

    // ------------------------------------------------------------
    // configuration register fields and reset value
    // ------------------------------------------------------------
    localparam int FSB_CFG_OW_EN = 0;
    localparam int FSB_CFG_AUTO_REC = 1;
    localparam int FSB_CFG_CTRL_EN = 2;
    localparam int FSB_CFG_CHAN_EN = 3;
    localparam int FSB_CFG_W = 4;
    localparam logic [FSB_CFG_W-1:0] FSB_CFG_RST = 4'h0;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int FSB_ST_GEN_ERR = 0;
    localparam int FSB_ST_CHAN_ERR = 1;
    localparam int FSB_ST_MEM_ERR = 2;
    localparam int FSB_ST_LED = 3;
    localparam int FSB_ST_CODE_LSB = 4;

    // ------------------------------------------------------------
    // flash counts per error class (0 means no flashing)
    // ------------------------------------------------------------
    localparam int FSB_CW = 3;
    localparam logic [FSB_CW-1:0] FSB_CODE_NONE = 3'h0;
    localparam logic [FSB_CW-1:0] FSB_CODE_SUPPLY = 3'h1;
    localparam logic [FSB_CW-1:0] FSB_CODE_OPEN_IN = 3'h2;
    localparam logic [FSB_CW-1:0] FSB_CODE_SHORT = 3'h3;
    localparam logic [FSB_CW-1:0] FSB_CODE_MEM = 3'h4;
    localparam logic [FSB_CW-1:0] FSB_CODE_BUS = 3'h5;
    localparam logic [FSB_CW-1:0] FSB_CODE_OPEN_SOL = 3'h6;
    localparam logic [FSB_CW-1:0] FSB_CODE_OTHER = 3'h7;

    // ------------------------------------------------------------
    // timing: a millisecond tick paces the flash sequence
    // ------------------------------------------------------------
    localparam int FSB_CLK_HZ = 50_000_000;
    localparam int FSB_TICK_MS = 1;
    localparam int FSB_TICK_CYCLES = FSB_CLK_HZ / 1000 * FSB_TICK_MS;
    localparam int FSB_FLASH_ON_MS = 250;
    localparam int FSB_FLASH_OFF_MS = 250;
    localparam int FSB_PAUSE_MS = 1500;
    localparam int FSB_TW = 12;
    localparam logic [FSB_TW-1:0] FSB_ON_TICKS = FSB_TW'(FSB_FLASH_ON_MS / FSB_TICK_MS);
    localparam logic [FSB_TW-1:0] FSB_OFF_TICKS = FSB_TW'(FSB_FLASH_OFF_MS / FSB_TICK_MS);
    localparam logic [FSB_TW-1:0] FSB_PAUSE_TICKS = FSB_TW'(FSB_PAUSE_MS / FSB_TICK_MS);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] din;
        logic [3:0] dout;
        logic [2:0] win;
        logic [1:0] thr;
        logic cval2;
        logic supply_low;
        logic cmd_out_lim;
        logic fb_out_lim;
        logic [1:0] sol_short;
        logic [1:0] sol_open;
        logic trail_over;
        logic bus_err;
        logic dout_short;
        logic dev_err;
        logic thr_err;
        logic mem_fault;
    } fsb_in_s;

    typedef enum logic [1:0] {
        FSB_IDLE = 2'b00,
        FSB_ON = 2'b01,
        FSB_OFF = 2'b10,
        FSB_PAUSE = 2'b11
    } fsb_state_e;

endpackage : fsb_pkg

/* File: src/fsb_fault_status.sv */
// fault latching, status words, blink code sequencer and apb register slave
`timescale 1ns/10ps
`default_nettype none

module fsb_fault_status
    import fsb_pkg::*;
#(
    parameter int TICK_CYCLES = FSB_TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [FSB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous monitor inputs
    input wire fsb_in_s mon_in,
    // indicators
    output logic led_red,
    output logic gen_error,
    output logic chan_error
);

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    fsb_in_s sync1;
    fsb_in_s sy;

    // two stages for every pin; only the second stage feeds logic
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= '0;
            sy <= '0;
        end else begin
            sync1 <= mon_in;
            sy <= sync1;
        end
    end

    // ------------------------------------------------------------
    // configuration register and enable edges
    // ------------------------------------------------------------
    logic [FSB_CFG_W-1:0] cfg;
    logic ctrl_en_q;
    logic chan_en_q;
    logic ctrl_rise;
    logic chan_rise;
    logic wr_acc;

    assign wr_acc = psel && penable && pwrite;

    // only byte lane 0 carries configuration bits
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= FSB_CFG_RST;
        end else if (wr_acc && paddr == FSB_OFS_CFG && pstrb[0]) begin
            cfg <= pwdata[FSB_CFG_W-1:0];
        end
    end

    // remember previous enables to see a disable/enable cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_en_q <= 1'b0;
            chan_en_q <= 1'b0;
        end else begin
            ctrl_en_q <= cfg[FSB_CFG_CTRL_EN];
            chan_en_q <= cfg[FSB_CFG_CHAN_EN];
        end
    end

    assign ctrl_rise = cfg[FSB_CFG_CTRL_EN] && !ctrl_en_q;
    assign chan_rise = cfg[FSB_CFG_CHAN_EN] && !chan_en_q;

    // ------------------------------------------------------------
    // latched faults (a new cause always wins over its clear)
    // ------------------------------------------------------------
    logic f_supply;
    logic f_cmd_ow;
    logic f_fb_ow;
    logic [1:0] f_short;
    logic [1:0] f_open;
    logic f_mem;
    logic cmd_ow_cause;
    logic fb_ow_cause;
    logic sup_clr;

    assign cmd_ow_cause = cfg[FSB_CFG_OW_EN] && sy.cmd_out_lim;
    assign fb_ow_cause = cfg[FSB_CFG_OW_EN] && sy.fb_out_lim;
    // restart of the control, or automatic recovery once supply is good again
    assign sup_clr = ctrl_rise || (cfg[FSB_CFG_AUTO_REC] && !sy.supply_low);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            f_supply <= 1'b0;
        end else begin
            f_supply <= sy.supply_low || (f_supply && !sup_clr);
        end
    end

    // per-channel faults clear on a channel disable/enable cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            f_cmd_ow <= 1'b0;
            f_fb_ow <= 1'b0;
            f_short <= 2'h0;
            f_open <= 2'h0;
        end else begin
            f_cmd_ow <= cmd_ow_cause || (f_cmd_ow && !chan_rise);
            f_fb_ow <= fb_ow_cause || (f_fb_ow && !chan_rise);
            f_short <= sy.sol_short | (f_short & {2{!chan_rise}});
            f_open <= sy.sol_open | (f_open & {2{!chan_rise}});
        end
    end

    // memory fault stays until sys_rst is asserted; no software clear exists
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            f_mem <= 1'b0;
        end else begin
            f_mem <= f_mem || sy.mem_fault;
        end
    end

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    logic [11:0] err_word;

    // bit n-1 of each word holds signal n; unlisted positions read zero
    always_comb begin
        err_word = 12'h000;
        err_word[0] = f_cmd_ow;
        err_word[1] = f_short[0];
        err_word[2] = f_short[1];
        err_word[3] = f_open[0];
        err_word[4] = f_open[1];
        err_word[5] = f_fb_ow;
        err_word[6] = sy.trail_over;
        err_word[7] = sy.bus_err;
        err_word[9] = sy.dout_short;
        err_word[10] = sy.dev_err;
        err_word[11] = sy.thr_err;
    end

    assign gen_error = f_supply;
    assign chan_error = |err_word[6:0] || f_mem;

    // ------------------------------------------------------------
    // flash code selection: lowest count wins
    // ------------------------------------------------------------
    logic [FSB_CW-1:0] code_sel;

    always_comb begin
        if (f_supply) begin
            code_sel = FSB_CODE_SUPPLY;
        end else if (f_cmd_ow || f_fb_ow) begin
            code_sel = FSB_CODE_OPEN_IN;
        end else if (|f_short) begin
            code_sel = FSB_CODE_SHORT;
        end else if (f_mem) begin
            code_sel = FSB_CODE_MEM;
        end else if (sy.bus_err) begin
            code_sel = FSB_CODE_BUS;
        end else if (|f_open || sy.trail_over) begin
            code_sel = FSB_CODE_OPEN_SOL;
        end else if (sy.dout_short || sy.dev_err || sy.thr_err) begin
            code_sel = FSB_CODE_OTHER;
        end else begin
            code_sel = FSB_CODE_NONE;
        end
    end

    // ------------------------------------------------------------
    // millisecond tick divider
    // ------------------------------------------------------------
    logic [31:0] div_cnt;
    logic tick;

    assign tick = (div_cnt == 32'(TICK_CYCLES - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= 32'h0;
        end else if (tick) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // blink sequencer
    // ------------------------------------------------------------
    fsb_state_e state;
    logic [FSB_TW-1:0] t_cnt;
    logic [FSB_CW-1:0] code_q;
    logic [FSB_CW-1:0] pulses;

    // code is taken at the start of a round so a round is never cut short
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= FSB_IDLE;
            t_cnt <= '0;
            code_q <= FSB_CODE_NONE;
            pulses <= '0;
        end else if (tick) begin
            unique case (state)
                FSB_IDLE: begin
                    if (code_sel != FSB_CODE_NONE) begin
                        state <= FSB_ON;
                        code_q <= code_sel;
                        pulses <= FSB_CW'(1);
                        t_cnt <= FSB_ON_TICKS - FSB_TW'(1);
                    end
                end
                FSB_ON: begin
                    if (t_cnt == '0) begin
                        if (pulses == code_q) begin
                            state <= FSB_PAUSE;
                            t_cnt <= FSB_PAUSE_TICKS - FSB_TW'(1);
                        end else begin
                            state <= FSB_OFF;
                            t_cnt <= FSB_OFF_TICKS - FSB_TW'(1);
                        end
                    end else begin
                        t_cnt <= t_cnt - FSB_TW'(1);
                    end
                end
                FSB_OFF: begin
                    if (t_cnt == '0) begin
                        state <= FSB_ON;
                        pulses <= pulses + FSB_CW'(1);
                        t_cnt <= FSB_ON_TICKS - FSB_TW'(1);
                    end else begin
                        t_cnt <= t_cnt - FSB_TW'(1);
                    end
                end
                FSB_PAUSE: begin
                    if (t_cnt == '0) begin
                        state <= FSB_IDLE;
                    end else begin
                        t_cnt <= t_cnt - FSB_TW'(1);
                    end
                end
            endcase
        end
    end

    // led lit only during a pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            led_red <= 1'b0;
        end else begin
            led_red <= (state == FSB_ON);
        end
    end

    // ------------------------------------------------------------
    // apb read path: data captured in setup, valid through access
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic next_err;

    always_comb begin
        next_rdata = 32'h0;
        next_err = 1'b0;
        unique case (paddr)
            FSB_OFS_DIN: next_rdata[7:0] = sy.din;
            FSB_OFS_DOUT: next_rdata[3:0] = sy.dout;
            FSB_OFS_ERR: next_rdata[11:0] = err_word;
            FSB_OFS_WIN: next_rdata[2:0] = sy.win;
            FSB_OFS_THR: next_rdata[1:0] = sy.thr;
            FSB_OFS_CVAL: next_rdata[0] = sy.cval2;
            FSB_OFS_STAT: begin
                next_rdata[FSB_ST_GEN_ERR] = f_supply;
                next_rdata[FSB_ST_CHAN_ERR] = chan_error;
                next_rdata[FSB_ST_MEM_ERR] = f_mem;
                next_rdata[FSB_ST_LED] = led_red;
                next_rdata[FSB_ST_CODE_LSB +: FSB_CW] = code_sel;
            end
            FSB_OFS_CFG: next_rdata[FSB_CFG_W-1:0] = cfg;
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : next_rdata;
            pslverr <= next_err || (pwrite && paddr != FSB_OFS_CFG);
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

endmodule : fsb_fault_status

`default_nettype wire

/* File: testbench/fsb_fault_status_sva.sv */
// checker of status words, fault latching and led timing at the block's ports
`timescale 1ns/10ps
`default_nettype none
module fsb_chk
    import fsb_pkg::*;
#(
    parameter int TICK_CYCLES = FSB_TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [FSB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // monitor and indicators
    input wire fsb_in_s mon_in,
    input wire logic led_red,
    input wire logic gen_error,
    input wire logic chan_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // read setup cycle; read data is loaded here
    wire logic rd_set = psel && !penable && !pwrite;
    unmapped_a: assert property (psel && !penable && paddr > FSB_OFS_CFG
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    din_word_a: assert property ($stable(mon_in.din) [*4] ##0 (rd_set && paddr == FSB_OFS_DIN)
        |=> prdata == {24'h0, $past(mon_in.din)}) else $error("input word wrong");
    dout_word_a: assert property ($stable(mon_in.dout) [*4] ##0 (rd_set && paddr == FSB_OFS_DOUT)
        |=> prdata == {28'h0, $past(mon_in.dout)}) else $error("output word wrong");
    win_word_a: assert property ($stable(mon_in.win) [*4] ##0 (rd_set && paddr == FSB_OFS_WIN)
        |=> prdata == {29'h0, $past(mon_in.win)}) else $error("window word wrong");
    supply_rise_a: assert property ($rose(gen_error) |-> $past(mon_in.supply_low, 2)
        || $past(mon_in.supply_low, 3) || $past(mon_in.supply_low, 4))
        else $error("supply fault without cause");
    supply_clear_a: assert property ($fell(gen_error) |-> !($past(mon_in.supply_low, 2)
        && $past(mon_in.supply_low, 3) && $past(mon_in.supply_low, 4)))
        else $error("supply fault cleared while present");
    mem_chan_a: assert property (mon_in.mem_fault [*5] |-> chan_error)
        else $error("memory fault not shown");
    flash_on_a: assert property ($rose(led_red) |-> led_red [*8])
        else $error("flash pulse too short");
    flash_off_a: assert property ($fell(led_red) |-> !led_red [*8])
        else $error("dark gap too short");
    cfg_back_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == FSB_OFS_CFG
        ##2 (rd_set && paddr == FSB_OFS_CFG) |=> prdata == {28'h0, $past(pwdata[3:0], 3)})
        else $error("config readback wrong");
endmodule : fsb_chk
bind fsb_fault_status fsb_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk(mclk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mon_in(mon_in), .led_red(led_red), .gen_error(gen_error), .chan_error(chan_error));
`default_nettype wire

/* File: testbench/fsb_host.sv */
// host model: apb master that reads status words and writes the config word
`timescale 1ns/10ps
`default_nettype none
module fsb_host
    import fsb_pkg::*;
(
    // clock
    input wire logic mclk,
    // apb master side
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [FSB_AW-1:0] paddr = '0,
    output logic [31:0] pwdata = '0,
    output logic [3:0] pstrb = 4'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // setup, access until pready, then release; address and data are
    // inverted on release so a slave latching late sees garbage, not a copy
    task automatic xfer(input logic w, input logic [FSB_AW-1:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e, output logic t);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        t = (n >= 50);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : fsb_host
`default_nettype wire

/* File: testbench/tb_fault_status_and_blink_code.sv */
// self-checking bench of the fault status and blink code block
`timescale 1ns/10ps
`default_nettype none
module tb_fault_status_and_blink_code
    import fsb_pkg::*;
;
    // short tick keeps the flash rounds within a few thousand cycles
    localparam int TICKS = 2;
    localparam int GAP = 400 * TICKS;
    localparam logic [7:0] WA[5] = '{FSB_OFS_DIN, FSB_OFS_DOUT, FSB_OFS_WIN, FSB_OFS_THR, FSB_OFS_CVAL};
    localparam int WW[5] = '{8, 4, 3, 2, 1};
    // error-word bit and flash count per monitor flag bit
    localparam int EB[12] = '{0, 11, 10, 9, 7, 6, 3, 4, 1, 2, 5, 0};
    localparam int CD[12] = '{0, 7, 7, 7, 5, 6, 6, 6, 3, 3, 2, 2};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    fsb_in_s mon_in = '0;
    logic psel, penable, pwrite, pready, pslverr, led_red, gen_error, chan_error;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    int errors = 0;
    int compares = 0;
    logic [31:0] q;
    logic e;
    always #10 mclk = ~mclk;
    fsb_fault_status #(.TICK_CYCLES(TICKS)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mon_in(mon_in),
        .led_red(led_red), .gen_error(gen_error), .chan_error(chan_error));
    fsb_host i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic t;
        i_host.xfer(w, a, d, q, e, t);
        if (t) begin
            errors++;
            $display("[FAIL] %0t bus hang", $time);
            tally_and_finish();
        end
    endtask : acc
    // registered flag is read off the edge, then the bench resumes on a rising edge
    task automatic chk_gen(input logic exp);
        @(negedge mclk);
        chk({31'h0, gen_error}, {31'h0, exp});
        @(posedge mclk);
    endtask : chk_gen
    // find a pause, then count rising edges of the led over one round
    task automatic flashes(input int exp);
        int n, dark, c;
        logic prev;
        dark = 0;
        n = 0;
        prev = 1'b0;
        for (c = 0; c < 40000 && dark < GAP; c++) begin
            @(posedge mclk);
            dark = led_red ? 0 : dark + 1;
        end
        for (dark = 0; c < 80000 && (n == 0 || dark < GAP); c++) begin
            @(posedge mclk);
            n += (led_red && !prev);
            prev = led_red;
            dark = led_red ? 0 : dark + 1;
        end
        if (c >= 80000) begin
            errors++;
            $display("[FAIL] %0t led round not seen", $time);
            tally_and_finish();
        end
        chk(32'(n), 32'(exp));
    endtask : flashes
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_map();
        for (int a = 0; a < 8; a++) begin
            acc(1'b0, 8'(4 * a), 32'h0);
            chk(q, 32'h0);
        end
        acc(1'b0, 8'h20, 32'h0);
        chk({q[30:0], e}, 32'h1);
        acc(1'b1, FSB_OFS_DIN, 32'hFF);
        chk({31'h0, e}, 32'h1);
        acc(1'b1, FSB_OFS_CFG, 32'hFFFF_FFFF);
        acc(1'b0, FSB_OFS_CFG, 32'h0);
        chk(q, 32'hF);
        acc(1'b1, FSB_OFS_CFG, 32'h0);
    endtask : sc_map
    task automatic sc_words();
        for (int i = 0; i < 8; i++) begin
            mon_in.din <= 8'h01 << i;
            mon_in.dout <= 4'(1 << i);
            mon_in.win <= 3'(1 << i);
            mon_in.thr <= 2'(1 << i);
            mon_in.cval2 <= (i == 0);
            repeat (4) @(posedge mclk);
            for (int j = 0; j < 5; j++) begin
                acc(1'b0, WA[j], 32'h0);
                chk(q, i < WW[j] ? 32'h1 << i : 32'h0);
            end
        end
    endtask : sc_words
    task automatic sc_errors();
        mon_in <= fsb_in_s'(31'h800);
        repeat (4) @(posedge mclk);
        acc(1'b0, FSB_OFS_ERR, 32'h0);
        chk(q, 32'h0);
        // drop the cause first, or it latches the moment checking is enabled
        mon_in <= '0;
        repeat (4) @(posedge mclk);
        acc(1'b1, FSB_OFS_CFG, 32'h9);
        for (int k = 1; k < 12; k++) begin
            mon_in <= fsb_in_s'(31'h1 << k);
            repeat (4) @(posedge mclk);
            acc(1'b0, FSB_OFS_ERR, 32'h0);
            chk(q, 32'h1 << EB[k]);
            acc(1'b0, FSB_OFS_STAT, 32'h0);
            chk(32'({q[6:4], q[2:0]}), 32'({3'(CD[k]), 1'b0, EB[k] <= 6, 1'b0}));
            mon_in[k] <= 1'b0;
            repeat (4) @(posedge mclk);
            acc(1'b0, FSB_OFS_ERR, 32'h0);
            chk(q, k >= 6 ? 32'h1 << EB[k] : 32'h0);
            acc(1'b1, FSB_OFS_CFG, 32'h1);
            acc(1'b1, FSB_OFS_CFG, 32'h9);
            acc(1'b0, FSB_OFS_ERR, 32'h0);
            chk(q, 32'h0);
        end
    endtask : sc_errors
    task automatic sc_supply();
        acc(1'b1, FSB_OFS_CFG, 32'h4);
        mon_in.supply_low <= 1'b1;
        mon_in.sol_short[0] <= 1'b1;
        repeat (4) @(posedge mclk);
        acc(1'b0, FSB_OFS_STAT, 32'h0);
        chk(32'(q[6:4]), 32'h1);
        chk_gen(1'b1);
        mon_in <= '0;
        repeat (4) @(posedge mclk);
        chk_gen(1'b1);
        acc(1'b1, FSB_OFS_CFG, 32'h0);
        acc(1'b1, FSB_OFS_CFG, 32'h4);
        acc(1'b0, FSB_OFS_STAT, 32'h0);
        chk(32'({q[6:4], q[0]}), 32'h6);
        acc(1'b1, FSB_OFS_CFG, 32'h6);
        mon_in.supply_low <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_gen(1'b1);
        mon_in.supply_low <= 1'b0;
        repeat (5) @(posedge mclk);
        chk_gen(1'b0);
    endtask : sc_supply
    task automatic sc_led();
        acc(1'b1, FSB_OFS_CFG, 32'h1);
        acc(1'b1, FSB_OFS_CFG, 32'h9);
        mon_in.cmd_out_lim <= 1'b1;
        flashes(2);
        mon_in <= '0;
        acc(1'b1, FSB_OFS_CFG, 32'h1);
        acc(1'b1, FSB_OFS_CFG, 32'h9);
        mon_in.trail_over <= 1'b1;
        flashes(6);
        mon_in <= '0;
    endtask : sc_led
    task automatic sc_mem();
        // let the clear of the previous scenario land before setting a new flag
        @(posedge mclk);
        mon_in.mem_fault <= 1'b1;
        repeat (6) @(posedge mclk);
        mon_in.mem_fault <= 1'b0;
        acc(1'b1, FSB_OFS_CFG, 32'h0);
        acc(1'b1, FSB_OFS_CFG, 32'hC);
        acc(1'b0, FSB_OFS_STAT, 32'h0);
        chk(32'({q[6:4], q[2]}), 32'h9);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        acc(1'b0, FSB_OFS_STAT, 32'h0);
        chk(q, 32'h0);
    endtask : sc_mem
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        sc_map();
        sc_words();
        sc_errors();
        sc_supply();
        sc_led();
        sc_mem();
        tally_and_finish();
    end
endmodule : tb_fault_status_and_blink_code
`default_nettype wire
